// ### verilog/flash_section_write_guard.v
// Write permission guard and programming sequencer for program flash
`timescale 1ns/1ps
`include "flash_guard_defines.vh"

// Overview of operation
// - Flash is built from 512-byte pages, the smallest erasable unit.
// - Erase covers whole pages only, one page or several at once.
// - Flash writes are one byte or one 16-bit word each.
// - Flash splits into consecutive boot, code and data regions of pages.
// - Writing the region the current instruction came from is refused.
// - Code region is programmable only by code running from boot.
// - Data region is programmable by code running from boot or code.
// - Boot code may write code, data and eeprom, never boot.
// - Code-region code may write only data region and eeprom.
// - Data-region code may program nothing at all.
// - Permitted code or data programming halts the cpu; eeprom does not.
// - Region sizes come in 512-byte blocks; zero boot means all boot.
// - Zero code size runs code to the end; small code removes it.
module flash_section_write_guard
(
    // Clock and reset
    input  wire                     clk,
    input  wire                     sys_rst,
    // Cpu programming request
    input  wire                     req_valid,
    input  wire [1:0]               req_op,
    input  wire                     req_eeprom,
    input  wire [`FG_ADDR_W-1:0]    req_addr,
    input  wire [15:0]              req_wdata,
    input  wire [`FG_NPAGE_W-1:0]   req_npages,
    input  wire [`FG_ADDR_W-1:0]    fetch_addr,
    // Section size configuration
    input  wire [`FG_SIZE_W-1:0]    boot_region_size,
    input  wire [`FG_SIZE_W-1:0]    code_region_size,
    // Memory completion
    input  wire                     mem_done,
    // Cpu answer
    output reg                      req_ready,
    output reg                      req_grant,
    output reg                      req_refuse,
    output reg                      cpu_halt,
    // Flash array command
    output reg                      flash_wr_en,
    output reg                      flash_erase_en,
    output reg  [`FG_ADDR_W-1:0]    flash_addr,
    output reg  [15:0]              flash_wdata,
    output reg  [1:0]               flash_byte_en,
    output reg  [`FG_NPAGE_W:0]     flash_npages,
    // Eeprom array command
    output reg                      ee_wr_en,
    output reg  [`FG_EE_ADDR_W-1:0] ee_addr,
    output reg  [7:0]               ee_wdata
);

    // ****************************************************************
    // Functions
    // ****************************************************************

    // Page number of a byte address, widened for compares
    function [`FG_SIZE_W-1:0] page_of;
        input [`FG_ADDR_W-1:0] addr;
        begin
            page_of = {2'b00, addr[`FG_ADDR_W-1:`FG_PAGE_SHIFT]};
        end
    endfunction

    // Permission of an executing region to program a target region
    function allowed;
        input [1:0] exec_rgn;
        input [1:0] tgt_rgn;
        begin
            case (exec_rgn)
                `FG_RGN_BOOT:
                    allowed = (tgt_rgn != `FG_RGN_BOOT);
                `FG_RGN_CODE:
                    allowed = (tgt_rgn == `FG_RGN_DATA) ||
                              (tgt_rgn == `FG_RGN_EE);
                `FG_RGN_DATA:
                    allowed = 1'b0;
                default:
                    allowed = 1'b0;
            endcase
        end
    endfunction

    // ****************************************************************
    // Captured request
    // ****************************************************************

    reg [1:0]               state_q;
    reg [1:0]               state_d;
    reg [1:0]               op_q;
    reg                     eeprom_q;
    reg [`FG_ADDR_W-1:0]    addr_q;
    reg [15:0]              wdata_q;
    reg [`FG_NPAGE_W-1:0]   npages_q;
    reg [`FG_ADDR_W-1:0]    fetch_q;

    // Request capture on acceptance
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            op_q     <= `FG_OP_WR_BYTE;
            eeprom_q <= 1'b0;
            addr_q   <= {`FG_ADDR_W{1'b0}};
            wdata_q  <= 16'h0000;
            npages_q <= {`FG_NPAGE_W{1'b0}};
            fetch_q  <= {`FG_ADDR_W{1'b0}};
        end
        else if (req_valid && req_ready)
        begin
            op_q     <= req_op;
            eeprom_q <= req_eeprom;
            addr_q   <= req_addr;
            wdata_q  <= req_wdata;
            npages_q <= req_npages;
            fetch_q  <= fetch_addr;
        end
    end

    // ****************************************************************
    // Section decode
    // ****************************************************************

    wire [`FG_SIZE_W-1:0] boot_end_page;
    wire [`FG_SIZE_W-1:0] code_end_page;
    wire [1:0]            exec_rgn;
    wire [1:0]            first_rgn;
    wire [1:0]            last_rgn;
    wire [`FG_SIZE_W-1:0] first_page;
    wire [`FG_SIZE_W-1:0] last_page;
    wire                  is_erase;

    flash_section_map u_map
    (
        .boot_region_size (boot_region_size),
        .code_region_size (code_region_size),
        .boot_end_page    (boot_end_page),
        .code_end_page    (code_end_page)
    );

    flash_region_lookup u_exec
    (
        .page          (page_of(fetch_q)),
        .boot_end_page (boot_end_page),
        .code_end_page (code_end_page),
        .region        (exec_rgn)
    );

    // First and last page touched by the request
    assign is_erase   = (op_q == `FG_OP_ERASE);
    assign first_page = page_of(addr_q);
    assign last_page  = is_erase ?
                        first_page + {3'b000, npages_q} : first_page;

    flash_region_lookup u_first
    (
        .page          (first_page),
        .boot_end_page (boot_end_page),
        .code_end_page (code_end_page),
        .region        (first_rgn)
    );

    flash_region_lookup u_last
    (
        .page          (last_page),
        .boot_end_page (boot_end_page),
        .code_end_page (code_end_page),
        .region        (last_rgn)
    );

    // ****************************************************************
    // Permission check
    // ****************************************************************

    reg permit;
    reg bad_op;

    // Regions are ordered boot, code, data so both ends settle a range
    always @*
    begin
        bad_op = (op_q != `FG_OP_WR_BYTE) && (op_q != `FG_OP_WR_WORD) &&
                 (op_q != `FG_OP_ERASE);
        if (eeprom_q)
            // eeprom writable from boot or code
            permit = !is_erase && (op_q == `FG_OP_WR_BYTE) &&
                     allowed(exec_rgn, `FG_RGN_EE);
        else if (bad_op || (last_page >= `FG_NUM_PAGES))
            permit = 1'b0;
        else
            // code region from boot, data region from boot or code
            permit = allowed(exec_rgn, first_rgn) &&
                     allowed(exec_rgn, last_rgn);
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Next state
    always @*
    begin
        state_d = state_q;
        case (state_q)
            `FG_ST_IDLE:
                if (req_valid && req_ready)
                    state_d = `FG_ST_CHECK;
            `FG_ST_CHECK:
                state_d = permit ? `FG_ST_WAIT : `FG_ST_IDLE;
            `FG_ST_WAIT:
                if (mem_done)
                    state_d = `FG_ST_IDLE;
            default:
                state_d = `FG_ST_IDLE;
        endcase
    end

    // State register
    always @(posedge clk)
    begin
        if (sys_rst)
            state_q <= `FG_ST_IDLE;
        else
            state_q <= state_d;
    end

    // Cpu side answers
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            req_ready  <= 1'b1;
            req_grant  <= 1'b0;
            req_refuse <= 1'b0;
            cpu_halt   <= 1'b0;
        end
        else
        begin
            req_grant  <= (state_q == `FG_ST_CHECK) && permit;
            req_refuse <= (state_q == `FG_ST_CHECK) && !permit;
            case (state_q)
                `FG_ST_IDLE:
                    if (req_valid && req_ready)
                        req_ready <= 1'b0;
                `FG_ST_CHECK:
                begin
                    req_ready <= !permit;
                    cpu_halt  <= permit && !eeprom_q;
                end
                `FG_ST_WAIT:
                    if (mem_done)
                    begin
                        req_ready <= 1'b1;
                        cpu_halt  <= 1'b0;
                    end
                default:
                begin
                    req_ready <= 1'b1;
                    cpu_halt  <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Memory commands
    // ****************************************************************

    // One-cycle command pulses with held address and data
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            flash_wr_en    <= 1'b0;
            flash_erase_en <= 1'b0;
            flash_addr     <= {`FG_ADDR_W{1'b0}};
            flash_wdata    <= 16'h0000;
            flash_byte_en  <= 2'h0;
            flash_npages   <= {(`FG_NPAGE_W+1){1'b0}};
            ee_wr_en       <= 1'b0;
            ee_addr        <= {`FG_EE_ADDR_W{1'b0}};
            ee_wdata       <= 8'h00;
        end
        else
        begin
            flash_wr_en    <= 1'b0;
            flash_erase_en <= 1'b0;
            ee_wr_en       <= 1'b0;
            if ((state_q == `FG_ST_CHECK) && permit)
            begin
                if (eeprom_q)
                begin
                    ee_wr_en <= 1'b1;
                    ee_addr  <= addr_q[`FG_EE_ADDR_W-1:0];
                    ee_wdata <= wdata_q[7:0];
                end
                else if (is_erase)
                begin
                    flash_erase_en <= 1'b1;
                    flash_addr     <= {addr_q[`FG_ADDR_W-1:`FG_PAGE_SHIFT],
                                       {`FG_PAGE_SHIFT{1'b0}}};
                    flash_npages   <= {1'b0, npages_q} + 6'h01;
                    flash_byte_en  <= 2'h0;
                end
                else if (op_q == `FG_OP_WR_WORD)
                begin
                    // word write, address bit 0 ignored
                    flash_wr_en   <= 1'b1;
                    flash_addr    <= {addr_q[`FG_ADDR_W-1:1], 1'b0};
                    flash_wdata   <= wdata_q;
                    flash_byte_en <= 2'h3;
                end
                else
                begin
                    flash_wr_en   <= 1'b1;
                    flash_addr    <= addr_q;
                    flash_wdata   <= {wdata_q[7:0], wdata_q[7:0]};
                    flash_byte_en <= addr_q[0] ? 2'h2 : 2'h1;
                end
            end
        end
    end

endmodule // flash_section_write_guard

// ### shared/flash_guard_defines.vh
// Constants for the flash section write guard
`ifndef FLASH_GUARD_DEFINES_VH
`define FLASH_GUARD_DEFINES_VH

// ****************************************************************
// Flash geometry
// ****************************************************************
`define FG_ADDR_W          15
`define FG_PAGE_SHIFT      9
`define FG_PAGE_BYTES      512
`define FG_PAGE_W          6
`define FG_NUM_PAGES       8'h40
`define FG_SIZE_W          8
`define FG_NPAGE_W         5
`define FG_EE_ADDR_W       8

// Default section sizes used when a size value runs past flash end
`define FG_BOOT_SIZE_DFLT  8'h00
`define FG_CODE_SIZE_DFLT  8'h00

// ****************************************************************
// Region codes
// ****************************************************************
`define FG_RGN_BOOT        2'h0
`define FG_RGN_CODE        2'h1
`define FG_RGN_DATA        2'h2
`define FG_RGN_EE          2'h3

// ****************************************************************
// Request operations
// ****************************************************************
`define FG_OP_WR_BYTE      2'h0
`define FG_OP_WR_WORD      2'h1
`define FG_OP_ERASE        2'h2

// ****************************************************************
// Controller states
// ****************************************************************
`define FG_ST_IDLE         2'h0
`define FG_ST_CHECK        2'h1
`define FG_ST_WAIT         2'h2

`endif

// ### verilog/flash_section_map.v
// Section boundary computation from the two size values
`timescale 1ns/1ps
`include "flash_guard_defines.vh"

module flash_section_map
(
    // Size values in page units
    input  wire [`FG_SIZE_W-1:0] boot_region_size,
    input  wire [`FG_SIZE_W-1:0] code_region_size,
    // Exclusive end pages of boot and code regions
    output reg  [`FG_SIZE_W-1:0] boot_end_page,
    output reg  [`FG_SIZE_W-1:0] code_end_page
);

    reg [`FG_SIZE_W-1:0] boot_sz;
    reg [`FG_SIZE_W-1:0] code_sz;

    // Boundary decode
    always @*
    begin
        // Sizes past flash end fall back to defaults
        boot_sz = (boot_region_size > `FG_NUM_PAGES) ?
                  `FG_BOOT_SIZE_DFLT : boot_region_size;
        code_sz = (code_region_size > `FG_NUM_PAGES) ?
                  `FG_CODE_SIZE_DFLT : code_region_size;
        if (boot_sz == 8'h00)
        begin
            boot_end_page = `FG_NUM_PAGES;
            code_end_page = `FG_NUM_PAGES;
        end
        else if (code_sz == 8'h00)
        begin
            boot_end_page = boot_sz;
            code_end_page = `FG_NUM_PAGES;
        end
        else if (code_sz <= boot_sz)
        begin
            boot_end_page = boot_sz;
            code_end_page = boot_sz;
        end
        else
        begin
            boot_end_page = boot_sz;
            code_end_page = code_sz;
        end
    end

endmodule // flash_section_map

// ### verilog/flash_region_lookup.v
// Maps a flash page number to its section
`timescale 1ns/1ps
`include "flash_guard_defines.vh"

module flash_region_lookup
(
    // Page under test and section bounds
    input  wire [`FG_SIZE_W-1:0] page,
    input  wire [`FG_SIZE_W-1:0] boot_end_page,
    input  wire [`FG_SIZE_W-1:0] code_end_page,
    // Section code
    output reg  [1:0]            region
);

    // Region compare
    always @*
    begin
        if (page < boot_end_page)
            region = `FG_RGN_BOOT;
        else if (page < code_end_page)
            region = `FG_RGN_CODE;
        else
            region = `FG_RGN_DATA;
    end

endmodule // flash_region_lookup

// ### dv/flash_guard_props.sv
// Assertion checker for the flash section write guard
`timescale 1ns/1ps
`include "flash_guard_defines.vh"

module flash_guard_props
(
    // Clock and reset
    input wire                   clk,
    input wire                   sys_rst,
    // Request handshake
    input wire                   req_valid,
    input wire                   req_ready,
    input wire                   req_grant,
    input wire                   req_refuse,
    input wire                   cpu_halt,
    input wire                   mem_done,
    // Memory commands
    input wire                   flash_wr_en,
    input wire                   flash_erase_en,
    input wire                   ee_wr_en,
    input wire [`FG_ADDR_W-1:0]  flash_addr,
    input wire [15:0]            flash_wdata,
    input wire [1:0]             flash_byte_en,
    input wire [`FG_NPAGE_W:0]   flash_npages
);
    wire fl_cmd = flash_wr_en | flash_erase_en;
    wire lane   = flash_wr_en & (flash_byte_en != 2'h3);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // ****************************************************************
    // Request sequences
    // ****************************************************************
    sequence s_taken;
        req_valid && req_ready;
    endsequence
    sequence s_answer;
        (!req_grant && !req_refuse) ##1 (req_grant ^ req_refuse);
    endsequence

    chk_answer_time: assert property (s_taken |=> s_answer)
        else $error("answer not two cycles after request");
    chk_ready_drop: assert property (s_taken |=> !req_ready)
        else $error("ready stayed high after request");
    chk_refuse_quiet: assert property (req_refuse |->
        !fl_cmd && !ee_wr_en && req_ready)
        else $error("command or busy on refusal");
    chk_cmd_granted: assert property ((fl_cmd || ee_wr_en) |-> req_grant)
        else $error("memory command without grant");
    chk_halt_flash: assert property (fl_cmd |-> cpu_halt)
        else $error("cpu not halted on flash command");
    chk_ee_nohalt: assert property (ee_wr_en |-> !cpu_halt)
        else $error("cpu halted on eeprom write");
    chk_halt_release: assert property (cpu_halt && mem_done |=>
        !cpu_halt && req_ready)
        else $error("halt not released after done");
    chk_word_lane: assert property (flash_wr_en && flash_byte_en == 2'h3
        |-> !flash_addr[0])
        else $error("word write on odd address");
    chk_byte_lane: assert property (lane |->
        flash_byte_en == {flash_addr[0], !flash_addr[0]}
        && flash_wdata[15:8] == flash_wdata[7:0])
        else $error("byte lane wrong");
    chk_erase_count: assert property (flash_erase_en |->
        flash_npages != 6'h00 && flash_npages <= 6'h20)
        else $error("erase page count out of range");
endmodule // flash_guard_props

bind flash_section_write_guard flash_guard_props i_flash_guard_props
(
    .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
    .req_ready(req_ready), .req_grant(req_grant), .req_refuse(req_refuse),
    .cpu_halt(cpu_halt), .mem_done(mem_done), .flash_wr_en(flash_wr_en),
    .flash_erase_en(flash_erase_en), .ee_wr_en(ee_wr_en),
    .flash_addr(flash_addr), .flash_wdata(flash_wdata),
    .flash_byte_en(flash_byte_en), .flash_npages(flash_npages)
);

// ### dv/flash_mem_model.sv
// Memory array model answering each command with a done pulse
`timescale 1ns/1ps

module flash_mem_model
(
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Command strobe and answer delay
    input  wire       cmd,
    input  wire [7:0] lat,
    // Completion pulse and command count
    output reg        mem_done,
    output reg  [7:0] n_cmds
);
    reg [7:0] cnt_q;

    // Countdown from lat, then one done pulse
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            cnt_q    <= 8'h00;
            mem_done <= 1'b0;
            n_cmds   <= 8'h00;
        end
        else
        begin
            mem_done <= (cnt_q == 8'h01) && !cmd;
            if (cmd)
            begin
                cnt_q  <= lat;
                n_cmds <= n_cmds + 8'h01;
            end
            else if (cnt_q != 8'h00)
                cnt_q <= cnt_q - 8'h01;
        end
    end
endmodule // flash_mem_model

// ### dv/flash_section_write_guard_tb.sv
// Self-checking testbench for the flash section write guard
`timescale 1ns/1ps
`include "flash_guard_defines.vh"

module flash_section_write_guard_tb;
    reg         clk, sys_rst, req_valid, req_eeprom;
    reg  [1:0]  req_op;
    reg  [14:0] req_addr, fetch_addr;
    reg  [15:0] req_wdata;
    reg  [4:0]  req_npages;
    reg  [7:0]  boot_sz, code_sz, lat;
    wire        mem_done, req_ready, req_grant, req_refuse, cpu_halt;
    wire        flash_wr_en, flash_erase_en, ee_wr_en;
    wire [14:0] flash_addr;
    wire [15:0] flash_wdata;
    wire [1:0]  flash_byte_en;
    wire [5:0]  flash_npages;
    wire [7:0]  ee_addr, ee_wdata, n_cmds;
    reg  [14:0] ex_a [0:2];
    reg  [14:0] tg_a [0:3];
    integer     n_errors, checks_done;
    // Short operation names keep scenario lines narrow
    localparam [1:0] OPB = `FG_OP_WR_BYTE;
    localparam [1:0] OPW = `FG_OP_WR_WORD;
    localparam [1:0] OPE = `FG_OP_ERASE;

    flash_section_write_guard i_flash_section_write_guard
    (
        .clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_op(req_op), .req_eeprom(req_eeprom), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_npages(req_npages),
        .fetch_addr(fetch_addr), .boot_region_size(boot_sz),
        .code_region_size(code_sz), .mem_done(mem_done),
        .req_ready(req_ready), .req_grant(req_grant),
        .req_refuse(req_refuse), .cpu_halt(cpu_halt),
        .flash_wr_en(flash_wr_en), .flash_erase_en(flash_erase_en),
        .flash_addr(flash_addr), .flash_wdata(flash_wdata),
        .flash_byte_en(flash_byte_en), .flash_npages(flash_npages),
        .ee_wr_en(ee_wr_en), .ee_addr(ee_addr), .ee_wdata(ee_wdata)
    );

    flash_mem_model i_flash_mem_model
    (
        .clk(clk), .sys_rst(sys_rst), .lat(lat),
        .cmd(flash_wr_en | flash_erase_en | ee_wr_en),
        .mem_done(mem_done), .n_cmds(n_cmds)
    );

    // ****************************************************************
    // Compare, request and closing tasks
    // ****************************************************************
    task chk_val(input [15:0] got, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task req(input [1:0] op, input ee, input [14:0] a, input [15:0] d,
             input [4:0] np, input [14:0] f, input g, input h);
        integer   k;
        reg [7:0] c0;
        reg [2:0] cmd_x;
    begin
        c0 = n_cmds;
        // Expected write, erase and eeprom strobes for this request
        cmd_x = {g && !ee && op != `FG_OP_ERASE,
                 g && !ee && op == `FG_OP_ERASE, g && ee};
        req_op = op;
        req_eeprom = ee;
        req_addr = a;
        req_wdata = d;
        req_npages = np;
        fetch_addr = f;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        @(negedge clk);
        chk_val(req_grant, g);
        chk_val({flash_wr_en, flash_erase_en, ee_wr_en}, cmd_x);
        chk_val(req_refuse, !g);
        chk_val(cpu_halt, h);
        @(negedge clk);
        chk_val(cpu_halt, h);
        k = 0;
        while (req_ready !== 1'b1 && k < 100)
        begin
            @(negedge clk);
            k = k + 1;
        end
        chk_val(req_ready, 1'b1);
        chk_val(n_cmds - c0, g);
    end
    endtask

    task complete_run;
    begin
        if (n_errors == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_table;
        integer e, t;
        reg     ok;
    begin
        for (e = 0; e < 3; e = e + 1)
            for (t = 0; t < 4; t = t + 1)
            begin
                ok = (e == 0 && t != 0) || (e == 1 && t >= 2);
                req(OPB, t == 3, tg_a[t], 16'h00A5, 5'h00, ex_a[e], ok,
                    ok && t != 3);
            end
    end
    endtask

    task t_lanes;
    begin
        req(OPW, 0, 15'h3003, 16'hBEEF, 5'h00, 15'h0100, 1, 1);
        chk_val(flash_addr, 15'h3002);
        chk_val(flash_byte_en, 2'h3);
        chk_val(flash_wdata, 16'hBEEF);
        req(OPB, 0, 15'h3005, 16'h1234, 5'h00, 15'h0A00, 1, 1);
        chk_val(flash_byte_en, 2'h2);
        chk_val(flash_wdata, 16'h3434);
        req(OPB, 1, 15'h0055, 16'h00C3, 5'h00, 15'h0A00, 1, 0);
        chk_val({ee_addr, ee_wdata}, 16'h55C3);
        req(2'h3, 0, 15'h3000, 16'h0000, 5'h00, 15'h0100, 0, 0);
        req(OPW, 1, 15'h0056, 16'h0000, 5'h00, 15'h0100, 0, 0);
    end
    endtask

    task t_erase;
    begin
        req(OPE, 0, 15'h1200, 16'h0000, 5'h04, 15'h0100, 1, 1);
        chk_val(flash_npages, 6'h05);
        chk_val(flash_addr[14:9], 6'h09);
        req(OPE, 0, 15'h4000, 16'h0000, 5'h1F, 15'h0100, 1, 1);
        chk_val(flash_npages, 6'h20);
        req(OPE, 0, 15'h4200, 16'h0000, 5'h1F, 15'h0100, 0, 0);
        req(OPE, 0, 15'h0E00, 16'h0000, 5'h01, 15'h0A00, 0, 0);
        req(OPE, 0, 15'h0600, 16'h0000, 5'h01, 15'h0100, 0, 0);
    end
    endtask

    task t_sizes;
    begin
        lat = 8'h1E;
        req(OPB, 0, 15'h4000, 16'h0011, 5'h00, 15'h0100, 1, 1);
        lat = 8'h02;
        boot_sz = 8'h00;
        req(OPB, 0, 15'h7000, 16'h0011, 5'h00, 15'h0000, 0, 0);
        boot_sz = 8'h50;
        req(OPB, 0, 15'h7000, 16'h0011, 5'h00, 15'h0100, 0, 0);
        boot_sz = 8'h04;
        code_sz = 8'h00;
        req(OPB, 0, 15'h7000, 16'h0011, 5'h00, 15'h0A00, 0, 0);
        req(OPB, 0, 15'h7000, 16'h0011, 5'h00, 15'h0100, 1, 1);
        code_sz = 8'h02;
        req(OPB, 0, 15'h2000, 16'h0011, 5'h00, 15'h0A00, 0, 0);
        req(OPB, 0, 15'h0A00, 16'h0011, 5'h00, 15'h0100, 1, 1);
        code_sz = 8'h08;
    end
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        complete_run;
    end

    initial
    begin
        {req_valid, req_eeprom, req_op, req_addr, fetch_addr} = 0;
        {req_wdata, req_npages} = 0;
        {n_errors, checks_done} = 0;
        boot_sz = 8'h04;
        code_sz = 8'h08;
        lat = 8'h02;
        ex_a[0] = 15'h0100;
        ex_a[1] = 15'h0A00;
        ex_a[2] = 15'h2000;
        tg_a[0] = 15'h0300;
        tg_a[1] = 15'h0C00;
        tg_a[2] = 15'h3000;
        tg_a[3] = 15'h0055;
        sys_rst = 1'b1;
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        chk_val({req_ready, cpu_halt}, 2'h2);
        t_table;
        t_lanes;
        t_erase;
        t_sizes;
        complete_run;
    end
endmodule // flash_section_write_guard_tb
